/* srab_pkg.sv */
/*
 * Constants and state types for the serial register bank.
 * Assumes a single system clock domain; the serial pins are asynchronous.
 */
package srab_pkg;

	localparam int NCTRL = 16;
	localparam int NSTAT = 8;

	// Frame layout: address in bits 6:0, access bit 7, data in 15:8
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] ADDR_BITS = 5'h07;
	localparam logic [4:0] DATA_FIRST = 5'h08;
	localparam int RW_BIT = 7;

	// Control register indices used by the logic and the checks
	localparam logic [3:0] IDX_MS = 4'h0;
	localparam logic [3:0] IDX_HW = 4'h1;
	localparam logic [3:0] IDX_WD = 4'h2;
	localparam logic [3:0] IDX_GPIO = 4'hc;

	// Field positions in mode_supply_control and hardware_config_control
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int VCC2_HI = 4;
	localparam int VCC2_LO = 3;
	localparam int FO_ON_POS = 5;
	localparam int HW_RSVD_POS = 2;
	localparam logic [1:0] MODE_SOFT_RESET = 2'h3;

	// Addresses, index 0 rightmost
	localparam logic [NCTRL-1:0][6:0] CTRL_ADDR = {7'h1e, 7'h19, 7'h18,
		7'h17, 7'h15, 7'h14, 7'h10, 7'h0d, 7'h0c, 7'h08, 7'h07, 7'h06,
		7'h05, 7'h03, 7'h02, 7'h01};
	localparam logic [NSTAT-1:0][6:0] STAT_ADDR = {7'h55, 7'h54, 7'h47,
		7'h46, 7'h44, 7'h43, 7'h42, 7'h40};
	localparam logic [6:0] ADDR_FAM_PROD = 7'h7e;

	// Implemented (non-reserved, writable) bits of each control register
	localparam logic [NCTRL-1:0][7:0] CTRL_WMASK = {8'hff, 8'hff, 8'hff,
		8'hff, 8'h77, 8'h77, 8'h70, 8'h77, 8'h77, 8'h3f, 8'ha7, 8'hc4,
		8'h20, 8'hf7, 8'hfb, 8'hff};

	// Values after power-on or soft reset
	localparam logic [NCTRL-1:0][7:0] CTRL_POR = '0;

	// Restart: kept bits hold, the others take the restart value
	localparam logic [NCTRL-1:0][7:0] CTRL_RST_KEEP = {{14{8'hff}},
		8'hd9, 8'h23};
	localparam logic [NCTRL-1:0][7:0] CTRL_RST_VAL = '0;

	typedef enum logic [2:0] {
		SR_IDLE = 3'b001,
		SR_ADDR = 3'b010,
		SR_DATA = 3'b100
	} srab_phase_t;

	typedef struct packed {
		logic sclk_m;
		logic sclk_s;
		logic sclk_d;
		logic cs_m;
		logic cs_s;
		logic cs_d;
		logic mosi_m;
		logic mosi_s;
		srab_phase_t phase;
		logic [4:0] cnt;
		logic [15:0] shift;
		logic [7:0] tx;
		logic miso;
		logic soft_pulse;
		logic [NCTRL-1:0][7:0] ctrl;
		logic [NSTAT-1:0][7:0] stat;
	} srab_state_t;

endpackage : srab_pkg

/* srab_bank.sv */
/*
 * Register bank behind the 16-bit serial command port of the base device.
 * Assumes the serial pins come from another clock domain (mode 0, data
 * LSB first, chip select active low) and that event inputs are synchronous.
 */
`timescale 1ns/10ps
module srab_bank import srab_pkg::*; #(
	parameter logic [7:0] FAM_PROD_ID = 8'h3c // Arbitrary identity value
) (
	// System
	input wire logic clock,
	input wire logic rst_n,
	// Serial pins
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Device events
	input wire logic restart_req,
	input wire logic hw_mode_upd,
	input wire logic [1:0] hw_mode_val,
	input wire logic hw_vcc2_off,
	input wire logic hw_fo_set,
	input wire logic [NSTAT-1:0][7:0] status_evt,
	// Register contents and soft reset pulse
	output logic [NCTRL-1:0][7:0] ctrl_regs,
	output logic [NSTAT-1:0][7:0] stat_regs,
	output logic soft_reset_pulse
);

	srab_state_t st_ff;
	srab_state_t nxt_st;

	logic sclk_rise;
	logic sclk_fall;
	logic cs_start;
	logic cs_end;
	logic commit;
	logic cmd_rw;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_data;
	logic [15:0] nxt_shift;

	function automatic logic [4:0] ctrl_idx(input logic [6:0] a);
		ctrl_idx = 5'h10;
		for (int i = 0; i < NCTRL; i++) begin
			if (a == CTRL_ADDR[i]) begin
				ctrl_idx = 5'(i);
			end
		end
	endfunction : ctrl_idx

	function automatic logic [3:0] stat_idx(input logic [6:0] a);
		stat_idx = 4'h8;
		for (int i = 0; i < NSTAT; i++) begin
			if (a == STAT_ADDR[i]) begin
				stat_idx = 4'(i);
			end
		end
	endfunction : stat_idx

	function automatic logic [7:0] rd_val(input logic [6:0] a,
		input srab_state_t s);
		logic [4:0] ci;
		logic [3:0] si;
		ci = ctrl_idx(a);
		si = stat_idx(a);
		rd_val = 8'h00;
		if (!ci[4]) begin
			rd_val = s.ctrl[ci[3:0]] & CTRL_WMASK[ci[3:0]];
		end else if (!si[3]) begin
			rd_val = s.stat[si[2:0]];
		end else if (a == ADDR_FAM_PROD) begin
			rd_val = FAM_PROD_ID;
		end
	endfunction : rd_val

	// Edges are taken from the second and third stages only
	assign sclk_rise = st_ff.sclk_s & ~st_ff.sclk_d;
	assign sclk_fall = ~st_ff.sclk_s & st_ff.sclk_d;
	assign cs_start = ~st_ff.cs_s & st_ff.cs_d;
	assign cs_end = st_ff.cs_s & ~st_ff.cs_d;
	assign commit = cs_end && (st_ff.cnt == FRAME_BITS);
	assign cmd_addr = st_ff.shift[6:0];
	assign cmd_rw = st_ff.shift[RW_BIT];
	assign cmd_data = st_ff.shift[15:8];
	assign nxt_shift = {st_ff.mosi_s, st_ff.shift[15:1]};

	always_comb begin
		logic [4:0] ci;
		logic [3:0] si;
		ci = ctrl_idx(cmd_addr);
		si = stat_idx(cmd_addr);
		nxt_st = st_ff;
		nxt_st.sclk_m = spi_clk;
		nxt_st.sclk_s = st_ff.sclk_m;
		nxt_st.sclk_d = st_ff.sclk_s;
		nxt_st.cs_m = spi_cs_n;
		nxt_st.cs_s = st_ff.cs_m;
		nxt_st.cs_d = st_ff.cs_s;
		nxt_st.mosi_m = spi_mosi;
		nxt_st.mosi_s = st_ff.mosi_m;
		nxt_st.soft_pulse = 1'b0;

		case (st_ff.phase)
			SR_IDLE: begin
				if (cs_start) begin
					nxt_st.cnt = 5'h00;
					nxt_st.miso = 1'b0;
					nxt_st.phase = SR_ADDR;
				end
			end
			SR_ADDR: begin
				if (cs_end) begin
					nxt_st.phase = SR_IDLE;
				end else if (sclk_rise) begin
					nxt_st.shift = nxt_shift;
					nxt_st.cnt = st_ff.cnt + 5'h01;
					if (st_ff.cnt == ADDR_BITS - 5'h01) begin
						nxt_st.tx = rd_val(nxt_shift[15:9], st_ff);
						nxt_st.phase = SR_DATA;
					end
				end
			end
			SR_DATA: begin
				if (cs_end) begin
					nxt_st.phase = SR_IDLE;
				end else if (sclk_rise) begin
					nxt_st.shift = nxt_shift;
					// Saturates so an overlong frame is never committed
					if (st_ff.cnt != 5'h1f) begin
						nxt_st.cnt = st_ff.cnt + 5'h01;
					end
				end else if (sclk_fall) begin
					// data in bits 8 to 15
					if (st_ff.cnt >= DATA_FIRST && st_ff.cnt < FRAME_BITS) begin
						nxt_st.miso = st_ff.tx[st_ff.cnt[2:0]];
					end else begin
						nxt_st.miso = 1'b0;
					end
				end
			end
			default: begin
				nxt_st.phase = SR_IDLE;
			end
		endcase

		if (commit && cmd_rw) begin
			if (!ci[4]) begin
				if (ci[3:0] == IDX_MS && cmd_data[MODE_HI:MODE_LO] ==
					MODE_SOFT_RESET) begin
					nxt_st.soft_pulse = 1'b1;
				end else begin
					nxt_st.ctrl[ci[3:0]] = (st_ff.ctrl[ci[3:0]] &
						~CTRL_WMASK[ci[3:0]]) |
						(cmd_data & CTRL_WMASK[ci[3:0]]);
				end
			end else if (!si[3]) begin
				// Write command clears a status register
				nxt_st.stat[si[2:0]] = 8'h00;
			end
		end

		if (hw_mode_upd) begin
			nxt_st.ctrl[IDX_MS][MODE_HI:MODE_LO] = hw_mode_val;
		end
		if (hw_vcc2_off) begin
			nxt_st.ctrl[IDX_MS][VCC2_HI:VCC2_LO] = 2'h0;
		end
		if (hw_fo_set) begin
			nxt_st.ctrl[IDX_HW][FO_ON_POS] = 1'b1;
		end
		for (int i = 0; i < NSTAT; i++) begin
			nxt_st.stat[i] = nxt_st.stat[i] | status_evt[i];
		end

		if (restart_req) begin
			for (int i = 0; i < NCTRL; i++) begin
				nxt_st.ctrl[i] = (nxt_st.ctrl[i] & CTRL_RST_KEEP[i]) |
					(CTRL_RST_VAL[i] & ~CTRL_RST_KEEP[i]);
			end
		end
		if (nxt_st.soft_pulse) begin
			nxt_st.ctrl = CTRL_POR;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.phase <= SR_IDLE;
			st_ff.cs_m <= 1'b1;
			st_ff.cs_s <= 1'b1;
			st_ff.cs_d <= 1'b1;
			st_ff.ctrl <= CTRL_POR;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign spi_miso = st_ff.miso;
	assign spi_miso_oe = ~st_ff.cs_s;
	assign ctrl_regs = st_ff.ctrl;
	assign stat_regs = st_ff.stat;
	assign soft_reset_pulse = st_ff.soft_pulse;

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	logic quiet;
	logic wr_soft;
	assign quiet = !restart_req && !hw_mode_upd && !hw_vcc2_off &&
		!hw_fo_set;
	assign wr_soft = commit && cmd_rw && cmd_addr == CTRL_ADDR[IDX_MS] &&
		cmd_data[MODE_HI:MODE_LO] == MODE_SOFT_RESET;

	property p_short_frame;
		cs_end && st_ff.cnt != FRAME_BITS && quiet |=> $stable(st_ff.ctrl);
	endproperty
	a_short_frame: assert property (p_short_frame)
		else $error("Control changed after a frame not 16 bits long");

	property p_read_keeps;
		commit && !cmd_rw && quiet |=> st_ff.ctrl == $past(st_ff.ctrl);
	endproperty
	a_read_keeps: assert property (p_read_keeps)
		else $error("Read command altered control contents");

	property p_write_gpio;
		commit && cmd_rw && cmd_addr == CTRL_ADDR[IDX_GPIO] && quiet
			|=> st_ff.ctrl[IDX_GPIO] == $past(cmd_data);
	endproperty
	a_write_gpio: assert property (p_write_gpio)
		else $error("Write data not stored in addressed register");

	property p_por;
		disable iff (1'b0) !rst_n |=> st_ff.ctrl == CTRL_POR;
	endproperty
	a_por: assert property (p_por)
		else $error("Reset did not load power-on values");

	property p_soft;
		wr_soft |=> soft_reset_pulse && st_ff.ctrl == CTRL_POR ##1
			!soft_reset_pulse;
	endproperty
	a_soft: assert property (p_soft)
		else $error("Soft reset command mishandled");

	property p_restart;
		restart_req && !commit |=> st_ff.ctrl[IDX_MS] ==
			($past(st_ff.ctrl[IDX_MS]) & CTRL_RST_KEEP[IDX_MS]);
	endproperty
	a_restart: assert property (p_restart)
		else $error("Restart value not applied");

	property p_fo_set;
		hw_fo_set && !restart_req && !wr_soft |=>
			st_ff.ctrl[IDX_HW][FO_ON_POS];
	endproperty
	a_fo_set: assert property (p_fo_set)
		else $error("Hardware event did not set its bit");

	property p_evt_wins;
		status_evt[0][0] |=> st_ff.stat[0][0];
	endproperty
	a_evt_wins: assert property (p_evt_wins)
		else $error("Status event lost");

	property p_rsvd_tx;
		// Only the cycle of capture: later shifts reuse these bits
		$rose(st_ff.phase == SR_DATA) &&
			st_ff.shift[15:9] == CTRL_ADDR[IDX_HW]
			|-> st_ff.tx[HW_RSVD_POS] == 1'b0;
	endproperty
	a_rsvd_tx: assert property (p_rsvd_tx)
		else $error("Reserved bit returned nonzero");

	property p_rsvd_store;
		st_ff.ctrl[IDX_HW][HW_RSVD_POS] == 1'b0;
	endproperty
	a_rsvd_store: assert property (p_rsvd_store)
		else $error("Read-only bit took written data");

	property p_wd_steady;
		$changed(st_ff.ctrl[IDX_WD]) |-> $past(commit || restart_req);
	endproperty
	a_wd_steady: assert property (p_wd_steady)
		else $error("Control bits changed without a host write");

	property p_old_data;
		commit && cmd_rw && cmd_addr == CTRL_ADDR[IDX_GPIO]
			|-> st_ff.tx == st_ff.ctrl[IDX_GPIO];
	endproperty
	a_old_data: assert property (p_old_data)
		else $error("Output data was not the pre-write contents");

	c_write: cover property (commit && cmd_rw);
	c_read: cover property (commit && !cmd_rw);
	c_soft: cover property (wr_soft);
	c_restart: cover property (restart_req);

endmodule : srab_bank

/* srab_host.sv */
/*
 * Serial host model that sends 16-bit commands to the register bank.
 * Assumes mode 0 timing at a 320 ns bit period, data sent LSB first.
 */
`timescale 1ns/10ps
module srab_host (
	// Serial pins
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// Short frames only when the caller asks for fewer bits
	task automatic xfer(input logic [6:0] addr, input logic wr,
		input logic [7:0] data, input int nbits, output logic [7:0] rx);
		logic [15:0] frame;
		frame = {data, wr, addr};
		rx = 8'h00;
		#37 spi_cs_n = 1'b0;
		#200;
		for (int i = 0; i < nbits; i++) begin
			spi_mosi = frame[i];
			// Long low phase gives the answer time to settle
			#200;
			if (i >= 8)
				rx[i-8] = spi_miso;
			spi_clk = 1'b1;
			#120 spi_clk = 1'b0;
		end
		#200 spi_cs_n = 1'b1;
		// Released data line must not look like a held value
		spi_mosi = ~spi_mosi;
		#400;
	endtask : xfer
endmodule : srab_host

/* test_srab_bank.sv */
/*
 * Self-checking bench for the serial register bank.
 * Assumes the host model in srab_host and the constants of srab_pkg.
 */
`timescale 1ns/10ps
module test_srab_bank import srab_pkg::*; ;
	localparam logic [7:0] FAM_ID = 8'h5a; // Arbitrary identity value
	logic clock, rst_n, spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	logic restart_req, hw_mode_upd, hw_vcc2_off, hw_fo_set;
	logic soft_reset_pulse;
	logic [1:0] hw_mode_val;
	logic [NSTAT-1:0][7:0] status_evt, stat_regs, exp_s;
	logic [NCTRL-1:0][7:0] ctrl_regs, exp_c;
	int err_count = 0;
	int n_tests = 0;
	int n_soft = 0;

	srab_bank #(.FAM_PROD_ID(FAM_ID)) i_dut (.clock(clock), .rst_n(rst_n),
		.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.restart_req(restart_req), .hw_mode_upd(hw_mode_upd),
		.hw_mode_val(hw_mode_val), .hw_vcc2_off(hw_vcc2_off),
		.hw_fo_set(hw_fo_set), .status_evt(status_evt),
		.ctrl_regs(ctrl_regs), .stat_regs(stat_regs),
		.soft_reset_pulse(soft_reset_pulse));
	srab_host i_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso));

	always #20 clock = ~clock;
	always @(posedge clock)
		if (soft_reset_pulse === 1'b1)
			n_soft++;

	task automatic tally_and_finish();
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic check_all();
		for (int i = 0; i < NCTRL; i++)
			chk(ctrl_regs[i], exp_c[i]);
		for (int i = 0; i < NSTAT; i++)
			chk(stat_regs[i], exp_s[i]);
	endtask : check_all

	// Commit lands a few clocks after chip select rises
	task automatic cmd(input logic [6:0] a, input logic wr,
		input logic [7:0] d, input int nb, output logic [7:0] rx);
		i_host.xfer(a, wr, d, nb, rx);
		repeat (6) @(negedge clock);
		chk({7'h00, spi_miso_oe}, 8'h00);
	endtask : cmd

	initial begin
		#1_000_000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		logic [7:0] rx, d;
		int k;
		clock = 1'b0;
		rst_n = 1'b0;
		{restart_req, hw_mode_upd, hw_vcc2_off, hw_fo_set} = 4'h0;
		hw_mode_val = 2'h0;
		status_evt = '0;
		exp_c = CTRL_POR;
		exp_s = '0;
		void'($urandom(32'h1bff));
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		check_all();
		for (int n = 0; n < 24; n++) begin
			k = $urandom_range(NCTRL - 1);
			d = 8'($urandom) & CTRL_WMASK[k];
			if (k == 0)
				d[7] = 1'b0;
			cmd(CTRL_ADDR[k], 1'b1, d, 16, rx);
			chk(rx, exp_c[k]);
			exp_c[k] = d;
			cmd(CTRL_ADDR[k], 1'b0, 8'($urandom), 16, rx);
			chk(rx, d);
			check_all();
		end
		cmd(CTRL_ADDR[1], 1'b1, 8'hff, 16, rx);
		exp_c[1] = CTRL_WMASK[1];
		cmd(CTRL_ADDR[1], 1'b0, 8'h00, 16, rx);
		chk(rx, 8'hfb);
		cmd(CTRL_ADDR[IDX_GPIO], 1'b1, 8'ha5, 16, rx);
		chk(rx, exp_c[IDX_GPIO]);
		exp_c[IDX_GPIO] = 8'ha5;
		cmd(CTRL_ADDR[2], 1'b1, ~exp_c[2] & CTRL_WMASK[2], 12, rx);
		cmd(7'h7f, 1'b1, 8'hff, 16, rx);
		cmd(ADDR_FAM_PROD, 1'b1, ~FAM_ID, 16, rx);
		cmd(ADDR_FAM_PROD, 1'b0, 8'h00, 16, rx);
		chk(rx, FAM_ID);
		check_all();
		cmd(CTRL_ADDR[1], 1'b1, 8'h00, 16, rx);
		exp_c[1] = 8'h00;
		cmd(CTRL_ADDR[0], 1'b1, 8'h3f, 16, rx);
		@(negedge clock);
		{hw_mode_upd, hw_fo_set, hw_mode_val} = 4'hd;
		@(negedge clock);
		{hw_mode_upd, hw_fo_set, hw_vcc2_off} = 3'h1;
		@(negedge clock);
		hw_vcc2_off = 1'b0;
		exp_c[0] = 8'h67;
		exp_c[1][FO_ON_POS] = 1'b1;
		@(negedge clock);
		check_all();
		for (int j = 0; j < NSTAT; j++) begin
			status_evt[j] = 8'($urandom) | 8'h01;
			exp_s[j] = status_evt[j];
			@(negedge clock);
			status_evt = '0;
			cmd(STAT_ADDR[j], 1'b0, 8'h00, 16, rx);
			chk(rx, exp_s[j]);
			cmd(STAT_ADDR[j], 1'b1, 8'h00, 16, rx);
			chk(rx, exp_s[j]);
			exp_s[j] = 8'h00;
			check_all();
		end
		restart_req = 1'b1;
		@(negedge clock);
		restart_req = 1'b0;
		for (int i = 0; i < NCTRL; i++)
			exp_c[i] = exp_c[i] & CTRL_RST_KEEP[i] | CTRL_RST_VAL[i]
				& ~CTRL_RST_KEEP[i];
		@(negedge clock);
		check_all();
		cmd(CTRL_ADDR[0], 1'b1, 8'hc0, 16, rx);
		exp_c = CTRL_POR;
		check_all();
		chk(8'(n_soft), 8'h01);
		tally_and_finish();
	end
endmodule : test_srab_bank
